// >>> crf_regfile.v
// programmer-visible core registers: banked data/address/frame, pc, stacks, flag word
// assumes: apb master on pclk; sequencer and alu on the same clock drive the core ports
`timescale 1ns/1ps
`include "crf_map.vh"

// Operation
// RULE_01 - thirteen registers, two banks of seven
// RULE_02 - data words 0,1 split into byte halves
// RULE_03 - data words 2:0 and 3:1 form longs
// RULE_04 - address words pair, word 1 upper
// RULE_05 - frame base and static base, 16 bits
// RULE_06 - 20-bit vector table base register
// RULE_07 - 20-bit program counter, next instruction
// RULE_08 - two stack pointers, u flag selects
// RULE_09 - u clears on hw ack, swi 0..31
// RULE_10 - flag word is eleven bits wide
// RULE_11 - carry takes alu carry or shift-out
// RULE_12 - software keeps debug flag at zero
// RULE_13 - zero flag set on zero result
// RULE_14 - sign flag set on negative result
// RULE_15 - bank flag routes bank accesses
// RULE_16 - overflow flag follows alu overflow
// RULE_17 - i flag gates, cleared on ack
// RULE_18 - accept only priority above level field
// RULE_19 - software writes reserved bit as zero
// RULE_20 - byte write keeps other half
module crf_regfile
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        core_wr_en,
    input  wire [3:0]  core_wr_idx,
    input  wire [3:0]  core_wr_strb,
    input  wire [31:0] core_wr_data,
    input  wire [3:0]  core_rd_idx,
    output reg  [31:0] core_rd_data,
    input  wire        sp_wr_en,
    input  wire [15:0] sp_wr_data,
    input  wire        pc_load,
    input  wire [19:0] pc_load_val,
    input  wire        alu_upd,
    input  wire [3:0]  alu_upd_mask,
    input  wire [1:0]  alu_size,
    input  wire [31:0] alu_result,
    input  wire        alu_carry,
    input  wire        alu_ovf,
    input  wire        irq_req,
    input  wire [2:0]  irq_prio,
    input  wire        int_ack,
    input  wire        int_ack_hw,
    input  wire        swi_exec,
    input  wire [5:0]  swi_num,
    output reg         irq_accept,
    output reg  [15:0] active_sp,
    output reg  [15:0] frame_base_out,
    output reg  [15:0] static_base_out,
    output reg  [19:0] vector_table_base_out,
    output reg  [19:0] program_counter_out,
    output reg  [10:0] status_flag_out
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    reg  [15:0] bank_reg [0:13];
    reg  [19:0] vtb_reg;
    reg  [19:0] pc_reg;
    reg  [15:0] usp_reg;
    reg  [15:0] isp_reg;
    reg  [15:0] sb_reg;
    reg  [10:0] flag_reg;
    reg  [10:0] flag_next;
    reg         wr_en;
    reg  [3:0]  wr_idx;
    reg  [3:0]  wr_strb;
    reg  [31:0] wr_data;
    reg         res_zero;
    reg         res_sign;
    integer     i;

    wire [3:0]  apb_idx  = paddr[5:2];
    wire        apb_miss = (paddr[7:6] != 2'h0) || (paddr[1:0] != 2'h0);
    wire        apb_wr   = psel && penable && pwrite && pready && !pslverr;
    wire        flag_b   = flag_reg[`CRF_FLG_B];
    wire        flag_u   = flag_reg[`CRF_FLG_U];
    wire [2:0]  processor_priority_level      = flag_reg[`CRF_FLG_IPL_HI:`CRF_FLG_IPL_LO];

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // which part of a write lands in bank slot n: {hit, from upper 16 bits}
    function [1:0] slot_sel;
        input [3:0]   idx;
        input integer n;
        begin
            slot_sel = 2'h0;
            if (idx == n[3:0])
                slot_sel = 2'h2;
            // RULE_03 long data pairs: word 2 or 3 is the upper half
            else if (idx == `CRF_IDX_LONG_LOW && (n == 0 || n == 2))
                slot_sel = (n == 2) ? 2'h3 : 2'h2;
            else if (idx == `CRF_IDX_LONG_HIGH && (n == 1 || n == 3))
                slot_sel = (n == 3) ? 2'h3 : 2'h2;
            // RULE_04 address pair, address word 1 upper
            else if (idx == `CRF_IDX_LONG_ADDR && (n == 4 || n == 5))
                slot_sel = (n == 5) ? 2'h3 : 2'h2;
        end
    endfunction

    // byte-lane merge; an unstrobed byte keeps its old value
    function [15:0] merge16;
        input [15:0] old;
        input [1:0]  sel;
        input [3:0]  strb;
        input [31:0] data;
        reg   [15:0] half;
        reg   [1:0]  s;
        begin
            half = sel[0] ? data[31:16] : data[15:0];
            s    = sel[0] ? strb[3:2] : strb[1:0];
            merge16 = old;
            if (sel[1])
            begin
                // RULE_02 RULE_20 independent byte halves
                merge16[15:8] = s[1] ? half[15:8] : old[15:8];
                merge16[7:0]  = s[0] ? half[7:0]  : old[7:0];
            end
        end
    endfunction

    // shared read mux for the apb and core read ports
    function [31:0] rd_word;
        input [3:0] idx;
        reg   [3:0] b;
        begin
            // RULE_15 bank flag picks the visible bank
            b = flag_b ? 4'h7 : 4'h0;
            rd_word = 32'h0;
            case (idx)
                `CRF_IDX_DATA0:     rd_word = {16'h0, bank_reg[b]};
                `CRF_IDX_DATA1:     rd_word = {16'h0, bank_reg[b + 4'h1]};
                `CRF_IDX_DATA2:     rd_word = {16'h0, bank_reg[b + 4'h2]};
                `CRF_IDX_DATA3:     rd_word = {16'h0, bank_reg[b + 4'h3]};
                `CRF_IDX_ADDR0:     rd_word = {16'h0, bank_reg[b + 4'h4]};
                `CRF_IDX_ADDR1:     rd_word = {16'h0, bank_reg[b + 4'h5]};
                `CRF_IDX_FRAME:     rd_word = {16'h0, bank_reg[b + 4'h6]};
                `CRF_IDX_VTB:       rd_word = {12'h0, vtb_reg};
                `CRF_IDX_PC:        rd_word = {12'h0, pc_reg};
                `CRF_IDX_USP:       rd_word = {16'h0, usp_reg};
                `CRF_IDX_ISP:       rd_word = {16'h0, isp_reg};
                `CRF_IDX_SB:        rd_word = {16'h0, sb_reg};
                // reserved bit 11 and above read as zero
                `CRF_IDX_FLAG:      rd_word = {21'h0, flag_reg};
                `CRF_IDX_LONG_LOW:  rd_word = {bank_reg[b + 4'h2], bank_reg[b]};
                `CRF_IDX_LONG_HIGH: rd_word = {bank_reg[b + 4'h3], bank_reg[b + 4'h1]};
                `CRF_IDX_LONG_ADDR: rd_word = {bank_reg[b + 4'h5], bank_reg[b + 4'h4]};
                default:            rd_word = 32'h0;
            endcase
        end
    endfunction

    // ----------------------------------------
    // write port arbitration
    // ----------------------------------------
    // one write port: the sequencer wins, a colliding apb write is dropped
    always @*
    begin
        wr_en   = core_wr_en || apb_wr;
        wr_idx  = core_wr_en ? core_wr_idx  : apb_idx;
        wr_strb = core_wr_en ? core_wr_strb : pstrb;
        wr_data = core_wr_en ? core_wr_data : pwdata;
    end

    // ----------------------------------------
    // banked registers
    // ----------------------------------------
    // RULE_01 two copies of the seven-word bank
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (i = 0; i < `CRF_SLOTS; i = i + 1)
                bank_reg[i] <= `CRF_RST_W16;
        end
        else
        begin
            for (i = 0; i < `CRF_SLOTS; i = i + 1)
                // RULE_15 only the selected bank takes writes
                if (wr_en && ((i / `CRF_BANK_SLOTS) == (flag_b ? 1 : 0)))
                    bank_reg[i] <= merge16(bank_reg[i], slot_sel(wr_idx, i % `CRF_BANK_SLOTS),
                                           wr_strb, wr_data);
        end
    end

    // ----------------------------------------
    // unbanked registers
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vtb_reg <= `CRF_RST_W20;
            pc_reg  <= `CRF_RST_W20;
            usp_reg <= `CRF_RST_W16;
            isp_reg <= `CRF_RST_W16;
            sb_reg  <= `CRF_RST_W16;
        end
        else
        begin
            // RULE_06 vector table base, lanes 0 to 2
            if (wr_en && wr_idx == `CRF_IDX_VTB)
            begin
                if (wr_strb[0])
                    vtb_reg[7:0] <= wr_data[7:0];
                if (wr_strb[1])
                    vtb_reg[15:8] <= wr_data[15:8];
                if (wr_strb[2])
                    vtb_reg[19:16] <= wr_data[19:16];
            end
            // RULE_07 only the sequencer moves the pc
            if (pc_load)
                pc_reg <= pc_load_val;
            // RULE_05 static base
            if (wr_en && wr_idx == `CRF_IDX_SB)
                sb_reg <= merge16(sb_reg, 2'h2, wr_strb, wr_data);
            // RULE_08 active stack write goes where the u flag points
            if (sp_wr_en && flag_u)
                usp_reg <= sp_wr_data;
            else if (wr_en && wr_idx == `CRF_IDX_USP)
                usp_reg <= merge16(usp_reg, 2'h2, wr_strb, wr_data);
            if (sp_wr_en && !flag_u)
                isp_reg <= sp_wr_data;
            else if (wr_en && wr_idx == `CRF_IDX_ISP)
                isp_reg <= merge16(isp_reg, 2'h2, wr_strb, wr_data);
        end
    end

    // ----------------------------------------
    // flag word
    // ----------------------------------------
    always @*
    begin
        case (alu_size)
            `CRF_SZ_BYTE:
            begin
                res_zero = (alu_result[7:0] == 8'h0);
                res_sign = alu_result[7];
            end
            `CRF_SZ_WORD:
            begin
                res_zero = (alu_result[15:0] == 16'h0);
                res_sign = alu_result[15];
            end
            default:
            begin
                res_zero = (alu_result == 32'h0);
                res_sign = alu_result[31];
            end
        endcase
    end

    // order: register write, then alu result, then interrupt entry on top
    always @*
    begin
        flag_next = flag_reg;
        // RULE_10 eleven stored bits; debug bit is software's to keep at zero
        if (wr_en && wr_idx == `CRF_IDX_FLAG)
        begin
            if (wr_strb[0])
                flag_next[7:0] = wr_data[7:0];
            if (wr_strb[1])
                flag_next[10:8] = wr_data[10:8];
        end
        if (alu_upd)
        begin
            // RULE_11 carry, borrow or shift-out
            if (alu_upd_mask[0])
                flag_next[`CRF_FLG_C] = alu_carry;
            // RULE_13 zero result
            if (alu_upd_mask[1])
                flag_next[`CRF_FLG_Z] = res_zero;
            // RULE_14 negative result
            if (alu_upd_mask[2])
                flag_next[`CRF_FLG_S] = res_sign;
            // RULE_16 overflow
            if (alu_upd_mask[3])
                flag_next[`CRF_FLG_O] = alu_ovf;
        end
        // RULE_17 acknowledge masks further interrupts
        if (int_ack)
            flag_next[`CRF_FLG_I] = 1'b0;
        // RULE_09 fall back to the interrupt stack
        if ((int_ack && int_ack_hw) || (swi_exec && swi_num <= `CRF_SWI_U_MAX))
            flag_next[`CRF_FLG_U] = 1'b0;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_reg <= `CRF_RST_FLAG;
        else
            flag_reg <= flag_next;
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // decode and read data are taken in the setup cycle, so the access phase
    // always ends in one cycle; a core write in that same cycle is not seen
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pready  <= 1'b1;
            // pc is read-only from the bus
            pslverr <= apb_miss || (pwrite && apb_idx == `CRF_IDX_PC);
            prdata  <= (pwrite || apb_miss) ? 32'h0 : rd_word(apb_idx);
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------
    // core-facing outputs
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_rd_data          <= 32'h0;
            irq_accept            <= 1'b0;
            active_sp             <= `CRF_RST_W16;
            frame_base_out        <= `CRF_RST_W16;
            static_base_out       <= `CRF_RST_W16;
            vector_table_base_out <= `CRF_RST_W20;
            program_counter_out   <= `CRF_RST_W20;
            status_flag_out       <= `CRF_RST_FLAG;
        end
        else
        begin
            core_rd_data          <= rd_word(core_rd_idx);
            // RULE_17 RULE_18 enabled and strictly above the level field
            irq_accept            <= irq_req && flag_reg[`CRF_FLG_I] && (irq_prio > processor_priority_level);
            // RULE_08 u=0 interrupt stack, u=1 user stack
            active_sp             <= flag_u ? usp_reg : isp_reg;
            frame_base_out        <= bank_reg[flag_b ? 13 : 6];
            static_base_out       <= sb_reg;
            vector_table_base_out <= vtb_reg;
            program_counter_out   <= pc_reg;
            status_flag_out       <= flag_reg;
        end
    end

endmodule // crf_regfile

// >>> crf_map.vh
// register indices, flag layout, reset values and operand size codes
// assumes: word index n sits at apb byte address 4*n
`ifndef CRF_MAP_VH
`define CRF_MAP_VH

// ----------------------------------------
// register indices (byte address = 4*index)
// ----------------------------------------
`define CRF_IDX_DATA0      4'h0
`define CRF_IDX_DATA1      4'h1
`define CRF_IDX_DATA2      4'h2
`define CRF_IDX_DATA3      4'h3
`define CRF_IDX_ADDR0      4'h4
`define CRF_IDX_ADDR1      4'h5
`define CRF_IDX_FRAME      4'h6
`define CRF_IDX_VTB        4'h7
`define CRF_IDX_PC         4'h8
`define CRF_IDX_USP        4'h9
`define CRF_IDX_ISP        4'ha
`define CRF_IDX_SB         4'hb
`define CRF_IDX_FLAG       4'hc
`define CRF_IDX_LONG_LOW   4'hd
`define CRF_IDX_LONG_HIGH  4'he
`define CRF_IDX_LONG_ADDR  4'hf
`define CRF_BANK_SLOTS     7
`define CRF_SLOTS          14

// ----------------------------------------
// flag word bit positions
// ----------------------------------------
`define CRF_FLG_C          0
`define CRF_FLG_D          1
`define CRF_FLG_Z          2
`define CRF_FLG_S          3
`define CRF_FLG_B          4
`define CRF_FLG_O          5
`define CRF_FLG_I          6
`define CRF_FLG_U          7
`define CRF_FLG_IPL_LO     8
`define CRF_FLG_IPL_HI     10
`define CRF_FLG_WIDTH      11

// ----------------------------------------
// reset values
// ----------------------------------------
`define CRF_RST_W16        16'h0000
`define CRF_RST_W20        20'h00000
`define CRF_RST_FLAG       11'h000

// ----------------------------------------
// alu operand size and misc
// ----------------------------------------
`define CRF_SZ_BYTE        2'h0
`define CRF_SZ_WORD        2'h1
`define CRF_SZ_LONG        2'h2
`define CRF_SWI_U_MAX      6'h1f

`endif

// >>> crf_regfile_assertions.sv
// checker on the register file ports
// assumes: bound into crf_regfile, everything on pclk
`timescale 1ns/1ps
module crf_regfile_assertions
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        core_wr_en,
    input wire        alu_upd,
    input wire [3:0]  alu_upd_mask,
    input wire [1:0]  alu_size,
    input wire [31:0] alu_result,
    input wire        alu_carry,
    input wire        irq_req,
    input wire [2:0]  irq_prio,
    input wire        irq_accept,
    input wire        int_ack,
    input wire        int_ack_hw,
    input wire        swi_exec,
    input wire [5:0]  swi_num,
    input wire [10:0] status_flag_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence setup;
        psel && !penable;
    endsequence
    // a register write in the same cycle is applied before the alu result, so the alu flag bits still win
    sequence alu_alone;
        alu_upd && !psel && !core_wr_en;
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    chk_ready_access: assert property (setup |=> pready && penable && psel)
        else $error("no answer in the access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    chk_pc_refused: assert property (psel && !penable && pwrite && paddr == 8'h20 |=> pslverr)
        else $error("pc write not refused");
    chk_unmapped_err: assert property (setup ##0 paddr[7:6] != 2'h0 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_no_request: assert property (!irq_req |=> !irq_accept)
        else $error("accept without request");
    chk_prio_zero: assert property (irq_prio == 3'h0 |=> !irq_accept)
        else $error("priority zero accepted");
    chk_ack_ien: assert property (int_ack |-> ##[1:2] !status_flag_out[6])
        else $error("ack left interrupts enabled");
    chk_hw_ack_u: assert property (int_ack && int_ack_hw |-> ##[1:2] !status_flag_out[7])
        else $error("hw ack left user stack");
    chk_swi_u: assert property (swi_exec && swi_num <= 6'h1f |-> ##[1:2] !status_flag_out[7])
        else $error("low swi left user stack");
    chk_zero_word: assert property (alu_alone ##0 alu_upd_mask[1] && alu_size == 2'h1 &&
        alu_result[15:0] == 16'h0 |-> ##[1:2] status_flag_out[2])
        else $error("zero flag not set");
    chk_carry_set: assert property (alu_alone ##0 alu_upd_mask[0] && alu_carry |-> ##[1:2] status_flag_out[0])
        else $error("carry not captured");
endmodule // crf_regfile_assertions

bind crf_regfile crf_regfile_assertions i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .core_wr_en, .alu_upd, .alu_upd_mask, .alu_size, .alu_result, .alu_carry, .irq_req,
    .irq_prio, .irq_accept, .int_ack, .int_ack_hw, .swi_exec, .swi_num, .status_flag_out);

// >>> crf_core_model.sv
// far-side model: sequencer and alu pulsing the core ports
// assumes: shares pclk with the register file; drives just after rising edges
`timescale 1ns/1ps
module crf_core_model
(
    input  wire        pclk,
    output reg         core_wr_en,
    output reg  [3:0]  core_wr_idx,
    output reg  [3:0]  core_wr_strb,
    output reg  [31:0] core_wr_data,
    output reg  [3:0]  core_rd_idx,
    output reg         sp_wr_en,
    output reg  [15:0] sp_wr_data,
    output reg         pc_load,
    output reg  [19:0] pc_load_val,
    output reg         alu_upd,
    output reg  [3:0]  alu_upd_mask,
    output reg  [1:0]  alu_size,
    output reg  [31:0] alu_result,
    output reg         alu_carry,
    output reg         alu_ovf,
    output reg         irq_req,
    output reg  [2:0]  irq_prio,
    output reg         int_ack,
    output reg         int_ack_hw,
    output reg         swi_exec,
    output reg  [5:0]  swi_num
);
    initial
    begin
        {core_wr_en, sp_wr_en, pc_load, alu_upd, irq_req, int_ack, int_ack_hw, swi_exec, irq_prio, swi_num} = 17'h0;
        {core_wr_idx, core_wr_strb, core_wr_data, core_rd_idx} = 44'h0;
        {sp_wr_data, pc_load_val, alu_upd_mask, alu_size, alu_result, alu_carry, alu_ovf} = 76'h0;
    end
    // ----------------------------------------
    // one-cycle operations, except irq, which holds its request level
    // ----------------------------------------
    // released write, alu result and stack data turn over: no stale value passes
    task done;
        @(posedge pclk);
        {core_wr_en, sp_wr_en, pc_load, alu_upd, int_ack, swi_exec} <= 6'h0;
        core_wr_data <= ~core_wr_data;
        alu_result   <= ~alu_result;
        sp_wr_data   <= ~sp_wr_data;
    endtask
    task cwr(input [3:0] i, input [3:0] s, input [31:0] d);
        @(posedge pclk);
        core_wr_en   <= 1'b1;
        core_wr_idx  <= i;
        core_wr_strb <= s;
        core_wr_data <= d;
        core_rd_idx  <= i;
        done;
    endtask
    task spw(input [15:0] d);
        @(posedge pclk);
        sp_wr_en   <= 1'b1;
        sp_wr_data <= d;
        done;
    endtask
    task pcl(input [19:0] v);
        @(posedge pclk);
        pc_load     <= 1'b1;
        pc_load_val <= v;
        done;
    endtask
    task alu(input [3:0] m, input [1:0] z, input [31:0] r, input c, input o);
        @(posedge pclk);
        {alu_upd, alu_upd_mask, alu_size, alu_result, alu_carry, alu_ovf} <= {1'b1, m, z, r, c, o};
        done;
    endtask
    task ack(input hw);
        @(posedge pclk);
        int_ack    <= 1'b1;
        int_ack_hw <= hw;
        done;
    endtask
    task swi(input [5:0] n);
        @(posedge pclk);
        swi_exec <= 1'b1;
        swi_num  <= n;
        done;
    endtask
    task irq(input r, input [2:0] p);
        @(posedge pclk);
        irq_req  <= r;
        irq_prio <= p;
    endtask
endmodule // crf_core_model

// >>> crf_tb.sv
// bench: apb master and core model around crf_regfile
// assumes: crf_map.vh on the include path
`timescale 1ns/1ps
`include "crf_map.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
    reg         pclk, presetn, psel, penable, pwrite, er;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, rd;
    reg  [3:0]  pstrb;
    wire [31:0] prdata, core_wr_data, alu_result, core_rd_data;
    wire        pready, pslverr, core_wr_en, sp_wr_en, pc_load, alu_upd, alu_carry, alu_ovf;
    wire        irq_req, int_ack, int_ack_hw, swi_exec, irq_accept;
    wire [3:0]  core_wr_idx, core_wr_strb, core_rd_idx, alu_upd_mask;
    wire [15:0] sp_wr_data, active_sp, frame_base_out, static_base_out;
    wire [19:0] pc_load_val, vector_table_base_out, program_counter_out;
    wire [1:0]  alu_size;
    wire [2:0]  irq_prio;
    wire [5:0]  swi_num;
    wire [10:0] status_flag_out;
    int         fail_count = 0, n_checks = 0, cyc = 0;
    crf_regfile i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .core_wr_en, .core_wr_idx, .core_wr_strb, .core_wr_data, .core_rd_idx, .core_rd_data,
        .sp_wr_en, .sp_wr_data, .pc_load, .pc_load_val, .alu_upd, .alu_upd_mask, .alu_size, .alu_result,
        .alu_carry, .alu_ovf, .irq_req, .irq_prio, .int_ack, .int_ack_hw, .swi_exec, .swi_num, .irq_accept,
        .active_sp, .frame_base_out, .static_base_out, .vector_table_base_out, .program_counter_out,
        .status_flag_out);
    crf_core_model i_core (.pclk, .core_wr_en, .core_wr_idx, .core_wr_strb, .core_wr_data, .core_rd_idx,
        .sp_wr_en, .sp_wr_data, .pc_load, .pc_load_val, .alu_upd, .alu_upd_mask, .alu_size, .alu_result,
        .alu_carry, .alu_ovf, .irq_req, .irq_prio, .int_ack, .int_ack_hw, .swi_exec, .swi_num);
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            end_of_test;
        end
    end
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input w, input [7:0] a, input [31:0] d, input [3:0] s);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        {psel, penable, pwdata} <= {2'b00, ~d};
    endtask
    task wr(input [3:0] i, input [31:0] d);
        apb(1'b1, {2'h0, i, 2'h0}, d, 4'hf);
    endtask
    task rchk(input [3:0] i, input [31:0] e);
        apb(1'b0, {2'h0, i, 2'h0}, 32'h0, 4'h0);
        `CHK(rd, e)
    endtask
    task status_flag_word(input [10:0] v);
        wr(`CRF_IDX_FLAG, {21'h0, v & 11'h7fd});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_words;
        rchk(`CRF_IDX_FLAG, 32'h0);
        wr(`CRF_IDX_DATA0, 32'h1234);
        apb(1'b1, 8'h00, 32'h00ab, 4'h1);
        rchk(`CRF_IDX_DATA0, 32'h12ab);
        apb(1'b1, 8'h00, 32'hcd00, 4'h2);
        rchk(`CRF_IDX_DATA0, 32'hcdab);
        wr(`CRF_IDX_DATA1, 32'h1111);
        i_core.cwr(`CRF_IDX_DATA1, 4'h2, 32'hee00);
        rchk(`CRF_IDX_DATA1, 32'hee11);
        `CHK(core_rd_data, 32'hee11)
        wr(`CRF_IDX_LONG_LOW, 32'h89abcdef);
        rchk(`CRF_IDX_DATA2, 32'h89ab);
        wr(`CRF_IDX_LONG_HIGH, 32'h76543210);
        rchk(`CRF_IDX_DATA3, 32'h7654);
        rchk(`CRF_IDX_DATA1, 32'h3210);
        wr(`CRF_IDX_LONG_ADDR, 32'h11112222);
        rchk(`CRF_IDX_ADDR1, 32'h1111);
        i_core.cwr(`CRF_IDX_LONG_ADDR, 4'hc, 32'h33440000);
        rchk(`CRF_IDX_ADDR0, 32'h2222);
        `CHK(core_rd_data, 32'h33442222)
    endtask
    task t_bank;
        status_flag_word(11'h010);
        wr(`CRF_IDX_DATA0, 32'h5555);
        wr(`CRF_IDX_FRAME, 32'h0abc);
        tick(2);
        `CHK(frame_base_out, 16'h0abc)
        status_flag_word(11'h000);
        rchk(`CRF_IDX_DATA0, 32'hcdef);
        `CHK(frame_base_out, 16'h0)
        status_flag_word(11'h010);
        rchk(`CRF_IDX_DATA0, 32'h5555);
        wr(`CRF_IDX_SB, 32'hffff1234);
        rchk(`CRF_IDX_SB, 32'h1234);
        wr(`CRF_IDX_VTB, 32'hfff12345);
        rchk(`CRF_IDX_VTB, 32'h12345);
        `CHK({static_base_out, vector_table_base_out}, 36'h123412345)
    endtask
    task t_pc_sp;
        apb(1'b1, 8'h20, 32'h1, 4'hf);
        `CHK(er, 1'b1)
        apb(1'b0, 8'h40, 32'h0, 4'h0);
        `CHK({er, rd}, 33'h100000000)
        i_core.pcl(20'habcde);
        rchk(`CRF_IDX_PC, 32'habcde);
        `CHK(program_counter_out, 20'habcde)
        status_flag_word(11'h000);
        i_core.spw(16'h1111);
        rchk(`CRF_IDX_ISP, 32'h1111);
        `CHK(active_sp, 16'h1111)
        status_flag_word(11'h080);
        i_core.spw(16'h2222);
        rchk(`CRF_IDX_USP, 32'h2222);
        rchk(`CRF_IDX_ISP, 32'h1111);
        `CHK(active_sp, 16'h2222)
    endtask
    task t_alu;
        i_core.alu(4'hf, `CRF_SZ_WORD, 32'h10000, 1'b1, 1'b0);
        tick(2);
        `CHK(status_flag_out & 11'h02d, 11'h005)
        i_core.alu(4'hf, `CRF_SZ_WORD, 32'h8000, 1'b0, 1'b1);
        tick(2);
        `CHK(status_flag_out & 11'h02d, 11'h028)
        i_core.alu(4'hf, `CRF_SZ_BYTE, 32'h100, 1'b0, 1'b0);
        tick(2);
        `CHK(status_flag_out & 11'h02d, 11'h004)
        i_core.alu(4'hf, `CRF_SZ_LONG, 32'h80000000, 1'b1, 1'b0);
        i_core.alu(4'h2, `CRF_SZ_WORD, 32'h1, 1'b0, 1'b1);
        tick(2);
        `CHK(status_flag_out & 11'h02d, 11'h009)
    endtask
    task t_irq;
        status_flag_word(11'h340);
        i_core.irq(1'b1, 3'h3);
        tick(3);
        `CHK(irq_accept, 1'b0)
        i_core.irq(1'b1, 3'h4);
        tick(3);
        `CHK(irq_accept, 1'b1)
        status_flag_word(11'h300);
        tick(3);
        `CHK(irq_accept, 1'b0)
        status_flag_word(11'h3c0);
        i_core.ack(1'b1);
        tick(2);
        `CHK(status_flag_out & 11'h0c0, 11'h000)
        `CHK(irq_accept, 1'b0)
        status_flag_word(11'h0c0);
        i_core.ack(1'b0);
        tick(2);
        `CHK(status_flag_out & 11'h0c0, 11'h080)
        i_core.swi(6'h20);
        tick(2);
        `CHK(status_flag_out[7], 1'b1)
        i_core.swi(6'h1f);
        tick(2);
        `CHK(status_flag_out[7], 1'b0)
    endtask
    // ----------------------------------------
    // run
    // ----------------------------------------
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = 47'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(status_flag_out, 11'h0)
        t_words;
        t_bank;
        t_pc_sp;
        t_alu;
        t_irq;
        end_of_test;
    end
endmodule // testbench
